// ==== rtl/vbi_data_line_inserter.sv ====
// Serializes caption, copy-control and widescreen data onto VBI lines.
// Assumes timing, pixel input and APB all on pclk; line_start marks hsync fall.
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
module vbi_data_line_inserter #(
  parameter int WSS_VIDEO_CYCLES = vbi_pkg::WSS_VIDEO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vbi_pkg::vbi_timing_t timing,
  input wire logic [7:0] pixel_in,
  output logic [7:0] pixel_out,
  output logic inserting
);

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
      r[i] = v[7 - i];
    return r;
  endfunction : rev8

  // Byte as sent: seven data bits LSB first, odd parity last
  function automatic logic [7:0] cc_byte(input logic [7:0] v);
    cc_byte = rev8({~^v[6:0], v[6:0]});
  endfunction : cc_byte

  function automatic logic [5:0] crc6(input logic [13:0] d);
    logic [5:0] c;
    logic fb;
    c = vbi_pkg::CRC_PRESET;
    fb = 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      fb = d[i] ^ c[5];
      c = {c[4:0], 1'b0} ^ (fb ? vbi_pkg::CRC_POLY : 6'h00);
    end
    return c;
  endfunction : crc6

  function automatic logic [19:0] rev20(input logic [19:0] v);
    logic [19:0] r;
    r = '0;
    for (int i = 0; i < 20; i++)
      r[i] = v[19 - i];
    return r;
  endfunction : rev20

  // Each widescreen bit is six elements: one as 111000, zero as 000111
  function automatic logic [83:0] biphase(input logic [13:0] w);
    logic [83:0] r;
    r = '0;
    for (int i = 0; i < 14; i++)
      r[83 - 6 * i -: 6] = w[i] ? 6'b111000 : 6'b000111;
    return r;
  endfunction : biphase

  // Registers
  logic [7:0] cc0_reg, cc1_reg, ext0_reg, ext1_reg;
  logic [7:0] cfg_reg, mid_reg, lo_reg, ctrl_reg;
  logic [31:0] prdata_reg;

  // Line engine
  vbi_pkg::vbi_kind_t kind_reg, kind_next;
  vbi_pkg::vbi_state_t state_reg, state_next;
  logic [12:0] lcnt_reg;
  logic [11:0] pcnt_reg;
  logic [7:0] nbits_reg;
  logic [vbi_pkg::SER_W-1:0] shreg_reg, load_vec;
  logic [11:0] start_cyc, bit_cyc;
  logic [7:0] pixel_reg;

  // APB decode
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pwrite;
  wire hit_cc0 = paddr == vbi_pkg::ADDR_CC_DATA0;
  wire hit_cc1 = paddr == vbi_pkg::ADDR_CC_DATA1;
  wire hit_ext0 = paddr == vbi_pkg::ADDR_CC_EXT0;
  wire hit_ext1 = paddr == vbi_pkg::ADDR_CC_EXT1;
  wire hit_cfg = paddr == vbi_pkg::ADDR_COPY_CFG;
  wire hit_mid = paddr == vbi_pkg::ADDR_COPY_MID;
  wire hit_lo = paddr == vbi_pkg::ADDR_COPY_LO;
  wire hit_ctrl = paddr == vbi_pkg::ADDR_CTRL;
  wire hit_stat = paddr == vbi_pkg::ADDR_STATUS;
  wire mapped = hit_cc0 | hit_cc1 | hit_ext0 | hit_ext1 | hit_cfg | hit_mid
    | hit_lo | hit_ctrl | hit_stat;
  wire [7:0] status = {3'h0, state_reg == vbi_pkg::ST_SEND, kind_reg};
  wire [7:0] rd_sel = hit_cc0 ? cc0_reg : hit_cc1 ? cc1_reg : hit_ext0 ? ext0_reg
    : hit_ext1 ? ext1_reg : hit_cfg ? cfg_reg : hit_mid ? mid_reg
    : hit_lo ? lo_reg : hit_ctrl ? ctrl_reg : hit_stat ? status : 8'h00;

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cc0_reg <= vbi_pkg::REG_RESET;
      cc1_reg <= vbi_pkg::REG_RESET;
      ext0_reg <= vbi_pkg::REG_RESET;
      ext1_reg <= vbi_pkg::REG_RESET;
      cfg_reg <= vbi_pkg::REG_RESET;
      mid_reg <= vbi_pkg::REG_RESET;
      lo_reg <= vbi_pkg::REG_RESET;
      ctrl_reg <= vbi_pkg::REG_RESET;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      if (wr_en && hit_cc0) cc0_reg <= pwdata[7:0];
      if (wr_en && hit_cc1) cc1_reg <= pwdata[7:0];
      if (wr_en && hit_ext0) ext0_reg <= pwdata[7:0];
      if (wr_en && hit_ext1) ext1_reg <= pwdata[7:0];
      if (wr_en && hit_cfg) cfg_reg <= pwdata[7:0];
      if (wr_en && hit_mid) mid_reg <= pwdata[7:0];
      if (wr_en && hit_lo) lo_reg <= pwdata[7:0];
      if (wr_en && hit_ctrl) ctrl_reg <= pwdata[7:0];
      if (setup) prdata_reg <= {24'h000000, rd_sel};
    end
  end

  // Line selection from the encoder's field and line counters
  wire pal = ctrl_reg[vbi_pkg::CTRL_PAL];
  wire odd = timing.field_odd;
  wire [9:0] ln = timing.line_num;
  wire is_cc_odd = !pal && odd && ln == vbi_pkg::LINE_CC_ODD; // RULE1 RULE23
  wire is_cc_even = !pal && !odd && ln == vbi_pkg::LINE_CC_EVEN; // RULE1 RULE5 RULE23
  wire cc_go = (is_cc_odd && ctrl_reg[vbi_pkg::CTRL_CC_EN])
    || (is_cc_even && ctrl_reg[vbi_pkg::CTRL_EXT_EN]);
  wire copy_go = !pal && ((odd && ln == vbi_pkg::LINE_COPY_ODD // RULE11
    && cfg_reg[vbi_pkg::CFG_ODD_EN]) || (!odd && ln == vbi_pkg::LINE_COPY_EVEN
    && cfg_reg[vbi_pkg::CFG_EVEN_EN])); // RULE12
  wire wss_go = pal && ln == vbi_pkg::LINE_WSS && cfg_reg[vbi_pkg::CFG_WSS_EN]; // RULE17 RULE20

  // Payload words, bit 0 first on the line
  wire [7:0] cc_b0 = cc_byte(is_cc_even ? ext0_reg : cc0_reg); // RULE4 RULE5
  wire [7:0] cc_b1 = cc_byte(is_cc_even ? ext1_reg : cc1_reg);
  wire [19:0] copy_raw = {cfg_reg[3:0], mid_reg, lo_reg}; // RULE14
  wire [5:0] copy_crc = crc6(copy_raw[13:0]);
  wire [19:0] copy_word = cfg_reg[vbi_pkg::CFG_AUTO_CRC]
    ? {copy_crc, copy_raw[13:0]} // RULE15
    : copy_raw; // RULE16
  wire [13:0] wss_word = {mid_reg[5:0], lo_reg}; // RULE19

  // Frames are captured at line start straight from the registers
  wire [vbi_pkg::SER_W-1:0] cc_vec = {vbi_pkg::CC_RUNIN, 2'b00, 1'b1, // RULE2 RULE3
    cc_b0, cc_b1, 111'h0}; // RULE4 RULE7
  wire [vbi_pkg::SER_W-1:0] copy_vec = {1'b1, rev20(copy_word), 123'h0}; // RULE13
  wire [vbi_pkg::SER_W-1:0] wss_vec = {vbi_pkg::WSS_RUNIN, vbi_pkg::WSS_STARTCODE,
    biphase(wss_word), 7'h00}; // RULE18

  assign kind_next = cc_go ? vbi_pkg::K_CC : copy_go ? vbi_pkg::K_COPY
    : wss_go ? vbi_pkg::K_WSS : vbi_pkg::K_NONE;
  assign load_vec = cc_go ? cc_vec : copy_go ? copy_vec : wss_vec;

  always_comb
  begin
    unique case (kind_reg)
      vbi_pkg::K_CC:
      begin
        start_cyc = 12'(vbi_pkg::CC_START_CYC);
        bit_cyc = 12'(vbi_pkg::CC_BIT_CYC);
      end
      vbi_pkg::K_COPY:
      begin
        start_cyc = 12'(vbi_pkg::COPY_START_CYC);
        bit_cyc = 12'(vbi_pkg::COPY_BIT_CYC);
      end
      default:
      begin
        start_cyc = 12'(vbi_pkg::WSS_START_CYC);
        bit_cyc = 12'(vbi_pkg::WSS_EL_CYC);
      end
    endcase
  end

  wire bit_end = pcnt_reg == bit_cyc - 12'd1;
  wire last_bit = nbits_reg == 8'd1;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      vbi_pkg::ST_WAIT:
        if (kind_reg != vbi_pkg::K_NONE && lcnt_reg == {1'b0, start_cyc})
          state_next = vbi_pkg::ST_SEND;
      vbi_pkg::ST_SEND:
        if (bit_end && last_bit)
          state_next = vbi_pkg::ST_HOLD;
      vbi_pkg::ST_HOLD:
        state_next = vbi_pkg::ST_HOLD;
    endcase
    if (timing.line_start)
      state_next = vbi_pkg::ST_WAIT;
  end

  wire video_back = kind_reg == vbi_pkg::K_WSS
    && lcnt_reg >= 13'(WSS_VIDEO_CYCLES); // RULE21
  // Inserted lines ignore pixel input outside the data too, except widescreen lines from 42.5 us on
  wire [7:0] px_next = kind_reg == vbi_pkg::K_NONE ? pixel_in
    : state_reg == vbi_pkg::ST_SEND ? (shreg_reg[vbi_pkg::SER_W-1]
      ? vbi_pkg::LVL_HIGH : vbi_pkg::LVL_BLANK)
    : video_back ? pixel_in : vbi_pkg::LVL_BLANK; // RULE6

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kind_reg <= vbi_pkg::K_NONE;
      state_reg <= vbi_pkg::ST_HOLD;
      lcnt_reg <= 13'h0000;
      pcnt_reg <= 12'h000;
      nbits_reg <= 8'h00;
      shreg_reg <= '0;
      pixel_reg <= vbi_pkg::LVL_BLANK;
    end
    else
    begin
      state_reg <= state_next;
      pixel_reg <= px_next;
      pcnt_reg <= (state_reg != vbi_pkg::ST_SEND || bit_end) ? 12'h000 : pcnt_reg + 12'd1;
      if (lcnt_reg != 13'h1fff) lcnt_reg <= lcnt_reg + 13'd1;
      if (state_reg == vbi_pkg::ST_SEND && bit_end)
      begin
        shreg_reg <= {shreg_reg[vbi_pkg::SER_W-2:0], 1'b0};
        nbits_reg <= nbits_reg - 8'd1;
      end
      if (timing.line_start)
      begin
        kind_reg <= kind_next; // RULE23
        lcnt_reg <= 13'h0000;
        shreg_reg <= load_vec; // RULE7
        nbits_reg <= cc_go ? vbi_pkg::CC_LEN : copy_go ? vbi_pkg::COPY_LEN
          : vbi_pkg::WSS_LEN;
      end
    end
  end

  assign pixel_out = pixel_reg;
  assign inserting = kind_reg != vbi_pkg::K_NONE;

  // Views of the frame just loaded, for the checks below
  wire [7:0] cc0_flip = rev8({1'b0, cc0_reg[6:0]});
  wire [7:0] ext0_flip = rev8({1'b0, ext0_reg[6:0]});
  wire [19:0] copy_sent = rev20(shreg_reg[142:123]);

  // Checks
  a_cc_line_kind: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    timing.line_start && is_cc_odd && ctrl_reg[vbi_pkg::CTRL_CC_EN]
    |=> kind_reg == vbi_pkg::K_CC)
    else $error("caption line not selected");

  a_cc_runin: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    timing.line_start && cc_go |=> shreg_reg[143:130] == 14'h2aaa)
    else $error("caption run-in pattern wrong");

  a_cc_start_bit: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    timing.line_start && cc_go |=> shreg_reg[129:127] == 3'b001 && nbits_reg == 8'd33)
    else $error("caption gap or start bit wrong");

  a_cc_odd_parity: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    timing.line_start && cc_go |=> ^shreg_reg[126:119] && ^shreg_reg[118:111])
    else $error("caption byte parity not odd");

  a_cc_ext_source: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    timing.line_start && cc_go && is_cc_even
    |=> shreg_reg[126:120] == $past(ext0_flip[7:1]))
    else $error("extended caption source wrong");

  a_cc_pixel_ignored: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
    kind_reg == vbi_pkg::K_CC && !timing.line_start
    |=> pixel_out == vbi_pkg::LVL_BLANK || pixel_out == vbi_pkg::LVL_HIGH)
    else $error("pixel input leaked onto caption line");

  a_copy_ntsc_only: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    timing.line_start && copy_go |-> !pal && (ln == 10'd20 || ln == 10'd283))
    else $error("copy-control on wrong line or standard");

  a_copy_field_en: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    timing.line_start && copy_go |-> cfg_reg[odd ? 5 : 6])
    else $error("copy-control field enable ignored");

  a_copy_ref_pulse: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    timing.line_start && copy_go |=> shreg_reg[143] && nbits_reg == 8'd21)
    else $error("copy-control reference pulse missing");

  a_copy_crc: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    timing.line_start && copy_go && cfg_reg[4]
    |=> copy_sent[19:14] == $past(copy_crc))
    else $error("automatic CRC wrong");

  a_wss_pal_only: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    timing.line_start ##1 kind_reg == vbi_pkg::K_WSS |-> $past(pal))
    else $error("widescreen sent outside PAL");

  a_wss_video_back: assert property (@(posedge pclk) disable iff (!presetn) // RULE21
    video_back && state_reg == vbi_pkg::ST_HOLD && !timing.line_start
    |=> pixel_out == $past(pixel_in))
    else $error("video not restored on line 23");

  a_cc_odd_source: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
    timing.line_start && cc_go && is_cc_odd
    |=> shreg_reg[126:120] == $past(cc0_flip[7:1]))
    else $error("caption data source wrong");

  a_cc_even_kind: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    timing.line_start && is_cc_even && ctrl_reg[vbi_pkg::CTRL_EXT_EN]
    |=> kind_reg == vbi_pkg::K_CC)
    else $error("extended caption line not selected");

  a_cc_off_line: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    timing.line_start && is_cc_odd && !ctrl_reg[vbi_pkg::CTRL_CC_EN]
    |=> kind_reg != vbi_pkg::K_CC)
    else $error("caption sent while disabled");

  a_cc_gap_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    kind_reg == vbi_pkg::K_CC && state_reg == vbi_pkg::ST_SEND
    && (nbits_reg == 8'd17 || nbits_reg == 8'd18 || nbits_reg == 8'd19)
    |-> shreg_reg[vbi_pkg::SER_W-1] == (nbits_reg == 8'd17))
    else $error("caption gap or start bit misplaced");

  a_send_counters: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    state_reg == vbi_pkg::ST_SEND |-> pcnt_reg < bit_cyc && nbits_reg != 8'd0)
    else $error("bit timer or element count out of range");

  a_line_restart: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    timing.line_start |=> state_reg == vbi_pkg::ST_WAIT && lcnt_reg == 13'h0000)
    else $error("line engine not restarted at line start");

  a_idle_pass: assert property (@(posedge pclk) disable iff (!presetn) // RULE23
    kind_reg == vbi_pkg::K_NONE && !timing.line_start
    |=> pixel_out == $past(pixel_in))
    else $error("plain line not passed through");

  a_copy_kind: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    timing.line_start && copy_go |=> kind_reg == vbi_pkg::K_COPY)
    else $error("copy-control line not selected");

  a_copy_low_bits: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    timing.line_start && copy_go
    |=> copy_sent[13:0] == {$past(mid_reg[5:0]), $past(lo_reg)})
    else $error("copy-control payload order wrong");

  a_copy_raw_bits: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    timing.line_start && copy_go && !cfg_reg[vbi_pkg::CFG_AUTO_CRC]
    |=> copy_sent == {$past(cfg_reg[3:0]), $past(mid_reg), $past(lo_reg)})
    else $error("copy-control word altered without auto CRC");

  a_wss_frame_head: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    timing.line_start && wss_go |=> shreg_reg[143:115] == vbi_pkg::WSS_RUNIN
    && shreg_reg[114:91] == vbi_pkg::WSS_STARTCODE && nbits_reg == 8'd137)
    else $error("widescreen run-in or start code wrong");

  a_wss_payload_ends: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    timing.line_start && wss_go
    |=> shreg_reg[90:85] == ($past(lo_reg[0]) ? 6'h38 : 6'h07)
    && shreg_reg[12:7] == ($past(mid_reg[5]) ? 6'h38 : 6'h07))
    else $error("widescreen payload source wrong");

  a_wss_line_off: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    timing.line_start && !cfg_reg[vbi_pkg::CFG_WSS_EN] |=> kind_reg != vbi_pkg::K_WSS)
    else $error("widescreen sent while disabled");

endmodule : vbi_data_line_inserter

// ==== rtl/vbi_pkg.sv ====
// Constants, register map and types for the VBI data line inserter.
// Assumes a 100 MHz pclk and line timing from the encoder on the same clock.
// Summary of operation
// RULE1: Caption on line 21 odd, 284 even
// RULE2: Caption opens with seven-cycle locked run-in
// RULE3: Two blank bits, then start bit one
// RULE4: Two bytes, seven data bits, odd parity
// RULE5: Even field line 284 uses extended registers
// RULE6: Own timing; pixel input ignored on 21/284
// RULE7: Single-buffered bytes go out next eligible line
// RULE8: Host loads bytes by line 20 or 283
// RULE9: Host writes zeros when nothing new
// RULE10: Host pairs control codes in one field
// RULE11: Copy-control on 20 odd, 283 even, NTSC
// RULE12: Config bits 5 and 6 enable per field
// RULE13: Twenty-bit copy word after reference pulse
// RULE14: Copy bits from lo, mid, config low nibble
// RULE15: Auto CRC fills bits 14-19, x6+x+1
// RULE16: Without auto CRC send all bits unchanged
// RULE17: Widescreen word on line 23, PAL only
// RULE18: Fourteen-bit widescreen word after run-in, start
// RULE19: Widescreen bits from lo and mid registers
// RULE20: Config bit 7 enables widescreen line
// RULE21: Line 23 video resumes after 42.5 us
// RULE22: Host sets widescreen bit 3 odd parity
// RULE23: Field and line counters pick insertion lines
package vbi_pkg;

  localparam int CLK_MHZ = 100;

  // Byte addresses on APB
  localparam logic [7:0] ADDR_CC_DATA0 = 8'h00;
  localparam logic [7:0] ADDR_CC_DATA1 = 8'h04;
  localparam logic [7:0] ADDR_CC_EXT0 = 8'h08;
  localparam logic [7:0] ADDR_CC_EXT1 = 8'h0c;
  localparam logic [7:0] ADDR_COPY_CFG = 8'h10;
  localparam logic [7:0] ADDR_COPY_MID = 8'h14;
  localparam logic [7:0] ADDR_COPY_LO = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // Field positions
  localparam int CFG_AUTO_CRC = 4;
  localparam int CFG_ODD_EN = 5;
  localparam int CFG_EVEN_EN = 6;
  localparam int CFG_WSS_EN = 7;
  localparam int CTRL_CC_EN = 0;
  localparam int CTRL_EXT_EN = 1;
  localparam int CTRL_PAL = 2;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Line numbers
  localparam logic [9:0] LINE_CC_ODD = 10'd21;
  localparam logic [9:0] LINE_CC_EVEN = 10'd284;
  localparam logic [9:0] LINE_COPY_ODD = 10'd20;
  localparam logic [9:0] LINE_COPY_EVEN = 10'd283;
  localparam logic [9:0] LINE_WSS = 10'd23;

  // Times in ns from the falling edge of horizontal sync
  localparam int CC_START_NS = 10500;
  localparam int CC_BIT_NS = 1986;
  localparam int COPY_START_NS = 11200;
  localparam int COPY_BIT_NS = 2235;
  localparam int WSS_START_NS = 11000;
  localparam int WSS_EL_NS = 200;
  localparam int WSS_VIDEO_NS = 42500;
  localparam int CC_START_CYC = CC_START_NS * CLK_MHZ / 1000;
  localparam int CC_BIT_CYC = CC_BIT_NS * CLK_MHZ / 1000;
  localparam int COPY_START_CYC = COPY_START_NS * CLK_MHZ / 1000;
  localparam int COPY_BIT_CYC = COPY_BIT_NS * CLK_MHZ / 1000;
  localparam int WSS_START_CYC = WSS_START_NS * CLK_MHZ / 1000;
  localparam int WSS_EL_CYC = WSS_EL_NS * CLK_MHZ / 1000;
  localparam int WSS_VIDEO_CYC = (WSS_VIDEO_NS * CLK_MHZ + 999) / 1000;

  // Serial frame layouts, first element in the MSB
  localparam int SER_W = 144;
  localparam logic [13:0] CC_RUNIN = 14'h2aaa;
  localparam logic [2:0] CC_GAP_START = 3'h1;
  localparam logic [7:0] CC_LEN = 8'd33;
  localparam logic [7:0] COPY_LEN = 8'd21;
  localparam logic [28:0] WSS_RUNIN = 29'h1f1c71c7;
  localparam logic [23:0] WSS_STARTCODE = 24'h1e3c1f;
  localparam logic [7:0] WSS_LEN = 8'd137;
  localparam logic [5:0] CRC_PRESET = 6'h3f;
  localparam logic [5:0] CRC_POLY = 6'h03;

  // Output levels
  localparam logic [7:0] LVL_BLANK = 8'h10;
  localparam logic [7:0] LVL_HIGH = 8'heb;

  typedef struct packed {
    logic line_start;
    logic field_odd;
    logic [9:0] line_num;
  } vbi_timing_t;

  typedef enum logic [3:0] {
    K_NONE = 4'b0001,
    K_CC = 4'b0010,
    K_COPY = 4'b0100,
    K_WSS = 4'b1000
  } vbi_kind_t;

  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_SEND = 3'b010,
    ST_HOLD = 3'b100
  } vbi_state_t;

endpackage : vbi_pkg

// ==== tb/vbi_data_line_inserter_tb.sv ====
// Bench for the VBI data line inserter: host model on APB, line timing here.
// Assumes the package constants for start times, bit periods and levels.
`timescale 1ns/10ps
module vbi_data_line_inserter_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, inserting, e;
  logic [7:0] paddr, pixel_out;
  logic [7:0] pixel_in = 8'h00;
  logic [31:0] pwdata, prdata, q;
  vbi_pkg::vbi_timing_t timing = '0;
  logic [143:0] f;
  int failures = 0;
  int checked = 0;
  int cnt = 0;
  int t0 = 0;

  always #5 pclk = ~pclk;
  always @(posedge pclk) cnt <= cnt + 1;

  vbi_data_line_inserter dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timing(timing), .pixel_in(pixel_in),
    .pixel_out(pixel_out), .inserting(inserting));
  vbi_host host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task complete_run;
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  task run_line(input logic [9:0] num, input logic odd);
    @(posedge pclk);
    timing <= '{1'b1, odd, num};
    pixel_in <= 8'h5a ^ num[7:0];
    t0 = cnt;
    @(posedge pclk);
    timing.line_start <= 1'b0;
  endtask : run_line

  task wait_at(input int t);
    while (cnt - t0 < t)
      @(posedge pclk);
    #1;
  endtask : wait_at

  // Sample mid-element so a one-cycle launch skew cannot flip the verdict
  task frame(input int st, input int per, input int n);
    for (int k = 0; k < n; k++)
    begin
      wait_at(st + 2 + k * per + per / 2);
      chk({24'h0, pixel_out}, {24'h0, f[n-1-k] ? vbi_pkg::LVL_HIGH : vbi_pkg::LVL_BLANK});
    end
    wait_at(st + 2 + n * per + 4);
  endtask : frame

  task status(input logic [3:0] kind, input logic ins);
    host_u.rd(vbi_pkg::ADDR_STATUS, q, e);
    chk({27'h0, inserting, q[3:0]}, {27'h0, ins, kind});
  endtask : status

  function automatic logic [7:0] ccb(input logic [6:0] d);
    logic [7:0] r;
    for (int i = 0; i < 7; i++)
      r[7 - i] = d[i];
    r[0] = ~^d;
    return r;
  endfunction : ccb

  task t_regs;
    for (int i = 0; i < 8; i++)
    begin
      host_u.rd(8'(4 * i), q, e);
      chk(q, {24'h0, vbi_pkg::REG_RESET});
    end
    host_u.wr(vbi_pkg::ADDR_COPY_LO, 32'hffff_ffa5);
    host_u.rd(vbi_pkg::ADDR_COPY_LO, q, e);
    chk(q, 32'h0000_00a5);
    host_u.rd(8'h24, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask : t_regs

  task t_caption(input logic [9:0] num, input logic odd, input logic [7:0] a,
                 input logic [6:0] b0, input logic [6:0] b1, input logic ld);
    if (ld)
      host_u.load_pair(a, {1'b0, b0}, {1'b0, b1});
    run_line(num, odd);
    status(4'h2, 1'b1);
    // Loaded mid-line, so these nulls belong to the next eligible line
    host_u.load_pair(a, 8'h00, 8'h00);
    f = {111'h0, 14'h2aaa, 3'b001, ccb(b0), ccb(b1)};
    frame(vbi_pkg::CC_START_CYC, vbi_pkg::CC_BIT_CYC, 33);
  endtask : t_caption

  task t_copy(input logic [9:0] num, input logic odd, input logic [7:0] cfg);
    logic [19:0] c;
    logic [5:0] crc;
    c = {cfg[3:0], 16'h5a3c};
    crc = 6'h3f;
    for (int i = 0; i < 14; i++)
      crc = {crc[4:0], 1'b0} ^ ((c[i] ^ crc[5]) ? 6'h03 : 6'h00);
    host_u.wr(vbi_pkg::ADDR_COPY_CFG, {24'h0, cfg});
    host_u.wr(vbi_pkg::ADDR_COPY_MID, 32'h5a);
    host_u.wr(vbi_pkg::ADDR_COPY_LO, 32'h3c);
    run_line(num, odd);
    status(4'h4, 1'b1);
    f = 144'h0;
    f[20] = 1'b1;
    for (int i = 0; i < 20; i++)
      f[19 - i] = (cfg[4] && i > 13) ? crc[i - 14] : c[i];
    frame(vbi_pkg::COPY_START_CYC, vbi_pkg::COPY_BIT_CYC, 21);
  endtask : t_copy

  task t_pass(input logic [9:0] num, input logic odd, input int t);
    run_line(num, odd);
    status(4'h1, 1'b0);
    wait_at(t);
    chk({24'h0, pixel_out}, {24'h0, 8'h5a ^ num[7:0]});
  endtask : t_pass

  task t_wss;
    logic [13:0] w;
    w = {6'h25, host_u.wss_lo(3'b011, 4'h9)};
    host_u.wr(vbi_pkg::ADDR_COPY_MID, 32'he5);
    host_u.wr(vbi_pkg::ADDR_COPY_LO, {24'h0, w[7:0]});
    host_u.wr(vbi_pkg::ADDR_COPY_CFG, 32'h80);
    run_line(10'd23, 1'b0);
    status(4'h8, 1'b1);
    f = {7'h0, vbi_pkg::WSS_RUNIN, vbi_pkg::WSS_STARTCODE, 84'h0};
    for (int i = 0; i < 14; i++)
      f[83 - 6 * i -: 6] = w[i] ? 6'b111000 : 6'b000111;
    frame(vbi_pkg::WSS_START_CYC, vbi_pkg::WSS_EL_CYC, 137);
    wait_at(vbi_pkg::WSS_VIDEO_CYC + 20);
    chk({24'h0, pixel_out}, {24'h0, 8'h5a ^ 8'd23});
  endtask : t_wss

  initial
  begin
    #900_000;
    failures++;
    complete_run();
  end

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    host_u.wr(vbi_pkg::ADDR_CTRL, 32'h1);
    t_caption(10'd21, 1'b1, vbi_pkg::ADDR_CC_DATA0, 7'h41, 7'h42, 1'b1);
    t_caption(10'd21, 1'b1, vbi_pkg::ADDR_CC_DATA0, 7'h00, 7'h00, 1'b0);
    t_pass(10'd22, 1'b1, 60);
    host_u.wr(vbi_pkg::ADDR_CTRL, 32'h3);
    t_caption(10'd284, 1'b0, vbi_pkg::ADDR_CC_EXT0, 7'h14, 7'h2c, 1'b1);
    t_copy(10'd20, 1'b1, 8'h35);
    t_copy(10'd283, 1'b0, 8'h4a);
    t_pass(10'd20, 1'b1, 2000);
    host_u.wr(vbi_pkg::ADDR_CTRL, 32'h4);
    t_pass(10'd283, 1'b0, 2000);
    t_pass(10'd23, 1'b1, 2000);
    t_wss();
    host_u.wr(vbi_pkg::ADDR_CTRL, 32'h0);
    t_pass(10'd23, 1'b1, 2000);
    complete_run();
  end
endmodule : vbi_data_line_inserter_tb

// ==== tb/vbi_host.sv ====
// Host model: APB master that loads the inserter's registers each field.
// Assumes an APB slave on pclk that raises pready in the access phase.
`timescale 1ns/10ps
module vbi_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench watchdog ends a wait for pready
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, a, d, q, e);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    xfer(1'b0, a, 32'h0, q, e);
  endtask : rd

  // Both bytes of a pair in one go; zeros when nothing new
  task load_pair(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1);
    wr(a, {24'h0, b0});
    wr(a + 8'h04, {24'h0, b1});
  endtask : load_pair

  function automatic logic [7:0] wss_lo(input logic [2:0] fmt, input logic [3:0] rest);
    return {rest, ~^fmt, fmt};
  endfunction : wss_lo
endmodule : vbi_host
